// *** shared/mcu_pkg.sv ***
// ---------------------------------------------------------------------------
// Shared constants for the metering control register block.
// ---------------------------------------------------------------------------
package mcu_pkg;

	// Bus geometry.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 6'h02;
	localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 6'h03;
	localparam logic [IDX_W-1:0] IDX_STATUS = 6'h04;

	// Reset value and writable bits of the control registers.
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CTRL_ONE_MASK = 32'hffff_ffff;
	localparam logic [DATA_W-1:0] CTRL_TWO_MASK = 32'h80ff_ffff;

	// Field positions.
	localparam int BIT_PERIOD_SEL = 31;
	localparam int BIT_COMP_DIS = 31;
	localparam int BIT_ACC_CLK_SEL = 23;
	localparam int BIT_LOW_SPEED = 22;
	localparam int BIT_VGAIN = 21;
	localparam int BIT_ZC_SRC = 20;
	localparam int BIT_ST_SETTLING = 0;
	localparam int BIT_ST_COMP = 1;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// System clock and derived timing.
	localparam longint CLK_HZ = 20000000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SETTLE_NS = 107000;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int SETTLE_W = 12;
	localparam int BASE_PERIOD_MS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int BASE_PERIOD_CYCLES = BASE_PERIOD_MS * NS_PER_MS /
		CLK_PERIOD_NS;
	localparam int BASE_CNT_W = 18;

	// Accumulator clock rates and phase increments of the rate generator.
	localparam longint ACC_FAST_HZ = 204800;
	localparam longint ACC_SLOW_HZ = 32768;
	localparam int PHASE_W = 32;
	localparam logic [63:0] INC_FAST_W = (64'(ACC_FAST_HZ) << PHASE_W) /
		64'(CLK_HZ);
	localparam logic [63:0] INC_SLOW_W = (64'(ACC_SLOW_HZ) << PHASE_W) /
		64'(CLK_HZ);
	localparam logic [PHASE_W-1:0] INC_FAST = INC_FAST_W[PHASE_W-1:0];
	localparam logic [PHASE_W-1:0] INC_SLOW = INC_SLOW_W[PHASE_W-1:0];

	// Sample widths.
	localparam int VSAMPLE_W = 24;
	localparam int VGAIN_SHIFT = 2;
	localparam int VSCALED_W = VSAMPLE_W + VGAIN_SHIFT;
	localparam int ISAMPLE_W = 24;

	// Two-bit divider of the base period.
	localparam logic [1:0] DIV_LAST = 2'h3;
	localparam logic [1:0] DIV_STEP = 2'h1;

endpackage : mcu_pkg

// *** logic/mcu_rate_gen.sv ***
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Fractional rate generator: one-cycle enable at the chosen average rate.
// ---------------------------------------------------------------------------
module mcu_rate_gen
	import mcu_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// Phase increment per system clock.
	input wire logic [PHASE_W-1:0] phase_inc,
	// Rate enable pulse.
	output logic tick
);

	logic [PHASE_W-1:0] phase_q;
	logic [PHASE_W-1:0] phase_d;
	logic tick_q;
	logic tick_d;
	logic [PHASE_W:0] sum;

	// The carry out of the accumulator is the tick; the jitter is one cycle,
	// traded for an exact long-term rate from a clock that is no multiple.
	always_comb begin
		sum = {1'b0, phase_q} + {1'b0, phase_inc};
		phase_d = sum[PHASE_W-1:0];
		tick_d = sum[PHASE_W];
	end

	// Registers.
	always_ff @(posedge clock) begin
		if (srst) begin
			phase_q <= '0;
			tick_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : mcu_rate_gen

// *** logic/mcu_ctrl_regs.sv ***
`timescale 1ns/1ns
// Operation
// - Top bit of control two set turns filter gain compensation off.
// - Compensation is forced off while direct-current metering runs.
// - Clock select bit picks 204.8 kHz (0) or 32.768 kHz (1).
// - Low-speed option clear: accumulators 3-8 every 20 ms or 40 ms.
// - Option set, period bit 0: accumulators 3-5 every 10 ms, 6-8 stop.
// - Voltage gain bit selects gain one (0) or gain four (1).
// - Zero-crossing source bit selects current channel A or B.
// - All fields reset to zero and are readable and writable.
// - Control one is a separate read-write word; its top bit picks period.
module mcu_ctrl_regs
	import mcu_pkg::*;
#(
	parameter int PERIOD_CYCLES = BASE_PERIOD_CYCLES
)
(
	// Clock and reset.
	input wire logic clock,
	input wire logic srst,
	// AXI4-Lite write address and data.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response.
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Metering datapath.
	input wire logic dc_metering_active,
	input wire logic signed [VSAMPLE_W-1:0] voltage_sample,
	input wire logic signed [ISAMPLE_W-1:0] current_channel_a,
	input wire logic signed [ISAMPLE_W-1:0] current_channel_b,
	output logic filter_comp_active,
	output logic accum_clock_tick,
	output logic accum_clock_settling,
	output logic accum_tick_group_a,
	output logic accum_tick_group_b,
	output logic signed [VSCALED_W-1:0] voltage_scaled,
	output logic signed [ISAMPLE_W-1:0] zero_cross_current,
	// Raw control words for the rest of the datapath.
	output logic [DATA_W-1:0] metering_control_one,
	output logic [DATA_W-1:0] metering_control_two
);

	// -----------------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------------
	function automatic logic [IDX_W-1:0] reg_index(
		input logic [ADDR_W-1:0] addr);
		return addr[IDX_LSB +: IDX_W];
	endfunction : reg_index

	function automatic logic [DATA_W-1:0] merge_write(
		input logic [DATA_W-1:0] old_val,
		input logic [DATA_W-1:0] new_val,
		input logic [3:0] strb,
		input logic [DATA_W-1:0] mask);
		logic [DATA_W-1:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res & mask;
	endfunction : merge_write

	// -----------------------------------------------------------------------
	// Register bus slave
	// -----------------------------------------------------------------------
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [DATA_W-1:0] ctrl_one_q, ctrl_one_d, ctrl_two_q, ctrl_two_d;
	logic [DATA_W-1:0] status_word;
	logic do_write;

	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready = !w_held_q;
	assign s_axi_arready = !rvalid_q;
	assign do_write = aw_held_q && w_held_q && !bvalid_q;

	// Address and data are caught in either order; the write happens once
	// both are held and the previous response has been taken.
	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ctrl_one_d = ctrl_one_q;
		ctrl_two_d = ctrl_two_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			waddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (reg_index(waddr_q))
				IDX_CTRL_ONE: begin
					ctrl_one_d = merge_write(ctrl_one_q, wdata_q, wstrb_q,
						CTRL_ONE_MASK);
				end
				IDX_CTRL_TWO: begin
					// Reserved bits are not stored and read back as zero.
					ctrl_two_d = merge_write(ctrl_two_q, wdata_q, wstrb_q,
						CTRL_TWO_MASK);
				end
				IDX_STATUS: ;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
	end

	// Read data is taken from the live registers in the address cycle.
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			unique case (reg_index(s_axi_araddr))
				IDX_CTRL_ONE: rdata_d = ctrl_one_q;
				IDX_CTRL_TWO: rdata_d = ctrl_two_q;
				IDX_STATUS: rdata_d = status_word;
				default: begin
					rdata_d = '0;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	// Bus and control registers.
	always_ff @(posedge clock) begin
		if (srst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			ctrl_one_q <= CTRL_RESET;
			ctrl_two_q <= CTRL_RESET;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_one_q <= ctrl_one_d;
			ctrl_two_q <= ctrl_two_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign metering_control_one = ctrl_one_q;
	assign metering_control_two = ctrl_two_q;

	// -----------------------------------------------------------------------
	// Datapath steering
	// -----------------------------------------------------------------------
	logic acc_sel, low_speed, period_sel;
	logic [PHASE_W-1:0] rate_inc;
	logic acc_sel_prev_q;
	logic [SETTLE_W-1:0] settle_q, settle_d;
	logic [BASE_CNT_W-1:0] base_cnt_q, base_cnt_d;
	logic [1:0] div_q, div_d;
	logic base_tick;
	logic comp_q, comp_d, tick_a_q, tick_a_d, tick_b_q, tick_b_d;
	logic signed [VSCALED_W-1:0] vscaled_q, vscaled_d;
	logic signed [ISAMPLE_W-1:0] zc_q, zc_d;

	assign acc_sel = ctrl_two_q[BIT_ACC_CLK_SEL];
	assign low_speed = ctrl_two_q[BIT_LOW_SPEED];
	assign period_sel = ctrl_one_q[BIT_PERIOD_SEL];
	assign rate_inc = acc_sel ? INC_SLOW : INC_FAST;
	assign base_tick = base_cnt_q == BASE_CNT_W'(PERIOD_CYCLES - 1);
	assign status_word = {{(DATA_W-2){1'b0}}, comp_q, settle_q != '0};

	mcu_rate_gen mcu_rate_gen_i (
		.clock(clock),
		.srst(srst),
		.phase_inc(rate_inc),
		.tick(accum_clock_tick)
	);

	// Settling window, group periods, gain and source selection. The
	// settling flag only reports; gating the pulse outputs is software's job.
	always_comb begin
		settle_d = settle_q;
		if (acc_sel != acc_sel_prev_q) begin
			settle_d = SETTLE_W'(SETTLE_CYCLES);
		end else if (settle_q != '0) begin
			settle_d = settle_q - SETTLE_W'(1);
		end
		base_cnt_d = base_tick ? '0 : base_cnt_q + BASE_CNT_W'(1);
		div_d = base_tick ? div_q + DIV_STEP : div_q;
		// The case with the option set and period bit one runs as cleared.
		if (low_speed && !period_sel) begin
			tick_a_d = base_tick;
			tick_b_d = 1'b0;
		end else if (!period_sel) begin
			tick_a_d = base_tick && div_q[0];
			tick_b_d = base_tick && div_q[0];
		end else begin
			tick_a_d = base_tick && div_q == DIV_LAST;
			tick_b_d = base_tick && div_q == DIV_LAST;
		end
		comp_d = !ctrl_two_q[BIT_COMP_DIS] && !dc_metering_active;
		vscaled_d = ctrl_two_q[BIT_VGAIN] ?
			VSCALED_W'(voltage_sample) <<< VGAIN_SHIFT :
			VSCALED_W'(voltage_sample);
		zc_d = ctrl_two_q[BIT_ZC_SRC] ? current_channel_b :
			current_channel_a;
	end

	// Datapath registers.
	always_ff @(posedge clock) begin
		if (srst) begin
			acc_sel_prev_q <= 1'b0;
			settle_q <= '0;
			base_cnt_q <= '0;
			div_q <= '0;
			tick_a_q <= 1'b0;
			tick_b_q <= 1'b0;
			comp_q <= 1'b0;
			vscaled_q <= '0;
			zc_q <= '0;
		end else begin
			acc_sel_prev_q <= acc_sel;
			settle_q <= settle_d;
			base_cnt_q <= base_cnt_d;
			div_q <= div_d;
			tick_a_q <= tick_a_d;
			tick_b_q <= tick_b_d;
			comp_q <= comp_d;
			vscaled_q <= vscaled_d;
			zc_q <= zc_d;
		end
	end

	assign accum_clock_settling = settle_q != '0;
	assign accum_tick_group_a = tick_a_q;
	assign accum_tick_group_b = tick_b_q;
	assign filter_comp_active = comp_q;
	assign voltage_scaled = vscaled_q;
	assign zero_cross_current = zc_q;

	// -----------------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	property p_comp_bit;
		!$past(srst) && !$past(dc_metering_active) |->
			filter_comp_active == !$past(ctrl_two_q[BIT_COMP_DIS]);
	endproperty
	a_comp_bit: assert property (p_comp_bit)
		else $error("Compensation does not follow its control bit.");

	property p_comp_dc;
		dc_metering_active |=> !filter_comp_active;
	endproperty
	a_comp_dc: assert property (p_comp_dc)
		else $error("Compensation active during DC metering.");

	property p_rate_sel;
		rate_inc == (ctrl_two_q[BIT_ACC_CLK_SEL] ? INC_SLOW : INC_FAST);
	endproperty
	a_rate_sel: assert property (p_rate_sel)
		else $error("Wrong accumulator clock rate selected.");

	sequence s_clk_change;
		$changed(acc_sel);
	endsequence
	property p_settle;
		s_clk_change |=> accum_clock_settling [*8];
	endproperty
	a_settle: assert property (p_settle)
		else $error("Settling flag not held after clock change.");

	property p_period_normal;
		tick_a_q && !$past(low_speed) && !$past(period_sel) |->
			$past(base_tick) && $past(div_q[0]);
	endproperty
	a_period_normal: assert property (p_period_normal)
		else $error("Group A tick off the 20 ms grid.");

	property p_fast_stop;
		$past(low_speed) && !$past(period_sel) |->
			!tick_b_q && tick_a_q == $past(base_tick);
	endproperty
	a_fast_stop: assert property (p_fast_stop)
		else $error("Low-speed 10 ms grouping wrong.");

	property p_vgain;
		!$past(srst) |->
			voltage_scaled == ($past(ctrl_two_q[BIT_VGAIN]) ?
			VSCALED_W'($past(voltage_sample)) <<< VGAIN_SHIFT :
			VSCALED_W'($past(voltage_sample)));
	endproperty
	a_vgain: assert property (p_vgain)
		else $error("Voltage gain wrong.");

	property p_zc_src;
		!$past(srst) |->
			zero_cross_current == ($past(ctrl_two_q[BIT_ZC_SRC]) ?
			$past(current_channel_b) : $past(current_channel_a));
	endproperty
	a_zc_src: assert property (p_zc_src)
		else $error("Zero-crossing source wrong.");

	property p_reset_zero;
		$past(srst) |-> ctrl_two_q == CTRL_RESET && ctrl_one_q == CTRL_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("Control registers not zero after reset.");

	property p_one_hold;
		!$past(srst) && !$past(do_write) |->
			ctrl_one_q == $past(ctrl_one_q);
	endproperty
	a_one_hold: assert property (p_one_hold)
		else $error("Control one changed without a write.");

endmodule : mcu_ctrl_regs

// *** tb/mcu_host_model.sv ***
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Host side model: an AXI4-Lite master that writes and reads single words.
// ---------------------------------------------------------------------------
module mcu_host_model
	import mcu_pkg::*;
(
	// Clock.
	input wire logic clock,
	// Write channels.
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	output logic [DATA_W-1:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// Read channels.
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	output logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp
);
	// Idle bus at time zero.
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'h0;
	end

	// Released payloads are inverted so that a stale value never looks valid.
	// Callers keep the reserved field of control two at zero.
	task automatic write_word(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [1:0] r, output bit ok);
		int n;
		ok = 0;
		r = 2'h3;
		@(posedge clock);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64 && !ok; n++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				ok = 1;
			end
		end
	endtask : write_word

	// One read; the answer is taken at the edge where rvalid is seen.
	task automatic read_word(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d, output logic [1:0] r, output bit ok);
		int n;
		ok = 0;
		r = 2'h3;
		d = '0;
		@(posedge clock);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64 && !ok; n++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				ok = 1;
			end
		end
	endtask : read_word
endmodule : mcu_host_model

// *** tb/mcu_ctrl_regs_bench.sv ***
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Register bench: bus calls with expected values.
// ---------------------------------------------------------------------------
module mcu_ctrl_regs_bench
	import mcu_pkg::*;
;
	localparam int P = 16;
	localparam logic [ADDR_W-1:0] C1 = {IDX_CTRL_ONE, 2'h0};
	localparam logic [ADDR_W-1:0] C2 = {IDX_CTRL_TWO, 2'h0};
	localparam logic [ADDR_W-1:0] ST = {IDX_STATUS, 2'h0};
	logic clock, srst, dc;
	logic signed [VSAMPLE_W-1:0] vs;
	logic signed [ISAMPLE_W-1:0] ia, ib;
	wire logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
	wire logic [ADDR_W-1:0] awa, ara;
	wire logic [DATA_W-1:0] wd, rd_data;
	wire logic [3:0] ws;
	wire logic [1:0] bresp, rresp;
	logic comp, tick, settle, ga, gb;
	logic signed [VSCALED_W-1:0] vsc;
	logic signed [ISAMPLE_W-1:0] zc;
	logic [DATA_W-1:0] mc1, mc2;
	int fail_count, comparisons, g, n, i;
	logic [1:0] mode [3] = '{2'b00, 2'b01, 2'b10};
	int exp_a [3] = '{2 * P, 4 * P, P};
	int exp_b [3] = '{2 * P, 4 * P, 200};

	mcu_ctrl_regs #(.PERIOD_CYCLES(P)) mcu_ctrl_regs_i (.clock(clock),
		.srst(srst), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .s_axi_rdata(rd_data), .s_axi_rresp(rresp),
		.dc_metering_active(dc), .voltage_sample(vs),
		.current_channel_a(ia), .current_channel_b(ib),
		.filter_comp_active(comp), .accum_clock_tick(tick),
		.accum_clock_settling(settle), .accum_tick_group_a(ga),
		.accum_tick_group_b(gb), .voltage_scaled(vsc),
		.zero_cross_current(zc), .metering_control_one(mc1),
		.metering_control_two(mc2));

	mcu_host_model mcu_host_model_i (.clock(clock), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd_data),
		.s_axi_rresp(rresp));

	// ------------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// A bus call that never completes ends the run as a failure.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [1:0] r;
		bit ok;
		mcu_host_model_i.write_word(a, d, r, ok);
		if (!ok) begin
			fail_count++;
			end_of_test();
		end else begin
			check(32'(r), 32'(er));
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bit ok;
		mcu_host_model_i.read_word(a, d, r, ok);
		if (!ok) begin
			fail_count++;
			end_of_test();
		end else begin
			check(d, ed);
			check(32'(r), 32'(er));
		end
	endtask : rd

	// Edges from one pulse to the next; lim means no pulse came.
	task automatic gap(input logic [2:0] s, input int lim, output int gv);
		int k;
		for (k = 0; k < lim && !(s & {tick, gb, ga}); k++) @(posedge clock);
		@(posedge clock);
		for (gv = 1; gv < lim && !(s & {tick, gb, ga}); gv++) begin
			@(posedge clock);
		end
	endtask : gap

	// ------------------------------------------------------------------
	// Clock, watchdog and main sequence.
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	initial begin
		#(50 * 100000);
		fail_count++;
		end_of_test();
	end

	initial begin
		fail_count = 0;
		comparisons = 0;
		srst = 1'b1;
		dc = 1'b0;
		vs = 24'sh000123;
		ia = 24'sh00aa01;
		ib = 24'sh00bb02;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(C1, 32'h0, RESP_OKAY);
		rd(C2, CTRL_RESET, RESP_OKAY);
		repeat (2) @(posedge clock);
		check(32'(comp), 32'h1);
		check(32'(zc), 32'(ia));
		check(32'(vsc), 32'h0000_0123);
		wr(C1, 32'hffff_ffff, RESP_OKAY);
		rd(C1, 32'hffff_ffff, RESP_OKAY);
		check(mc1, 32'hffff_ffff);
		wr(C2, 32'h80ff_ffff, RESP_OKAY);
		rd(C2, CTRL_TWO_MASK, RESP_OKAY);
		check(mc2, CTRL_TWO_MASK);
		repeat (3) @(posedge clock);
		check(32'(comp), 32'h0);
		check(32'(vsc), 32'h0000_048c);
		check(32'(zc), 32'(ib));
		rd(ST, 32'h1, RESP_OKAY);
		wr(C2, 32'h0, RESP_OKAY);
		for (n = 0; n < 3000 && settle; n++) @(posedge clock);
		// The flag is read before each edge updates it: one edge more.
		check(32'(n), 32'(SETTLE_CYCLES + 1));
		rd(ST, 32'h2, RESP_OKAY);
		dc <= 1'b1;
		vs <= -24'sd5;
		repeat (3) @(posedge clock);
		check(32'(comp), 32'h0);
		check(32'(vsc), 32'hffff_fffb);
		dc <= 1'b0;
		wr(8'h40, 32'h1, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
		gap(3'h4, 1000, g);
		gap(3'h4, 1000, g);
		check(32'(g == 97 || g == 98), 32'h1);
		wr(C2, 32'h0080_0000, RESP_OKAY);
		gap(3'h4, 1000, g);
		gap(3'h4, 1000, g);
		check(32'(g == 610 || g == 611), 32'h1);
		for (i = 0; i < 3; i++) begin
			wr(C1, {mode[i][0], 31'h0}, RESP_OKAY);
			wr(C2, {9'h0, mode[i][1], 22'h0}, RESP_OKAY);
			gap(3'h1, 200, g);
			gap(3'h1, 200, g);
			check(32'(g), 32'(exp_a[i]));
			gap(3'h2, 200, g);
			gap(3'h2, 200, g);
			check(32'(g), 32'(exp_b[i]));
		end
		end_of_test();
	end
endmodule : mcu_ctrl_regs_bench
